// File: rtl/flash_host_cfg.svh
// Register offsets, field positions and timing counts of the flash host
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_WDATA 8'h08
`define OFS_STATUS 8'h0C
`define OFS_RDATA 8'h10
`define OFS_TIMING 8'h14
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 4
`define CTRL_BYTE_BIT 8
`define ST_BUSY_BIT 0
`define ST_RDY_BIT 1
`define TIMING_RESET 32'h0000_0004
`define STROBE_CYC_MIN 4'h1
`define SECTOR_GAP_NS 50000
`define CLK_NS 8
`define SECTOR_GAP_CYC ((`SECTOR_GAP_NS / `CLK_NS) - 1)
`define UNLOCK1_W 12'h555
`define UNLOCK2_W 12'h2AA
`define UNLOCK1_B 12'hAAA
`define UNLOCK2_B 12'h555
`define D_UNLOCK1 8'hAA
`define D_UNLOCK2 8'h55
`define D_AUTOSEL 8'h90
`define D_PROGRAM 8'hA0
`define D_ERASE_SETUP 8'h80
`define D_CHIP_ERASE 8'h10
`define D_SECTOR_ERASE 8'h30
`define D_RESUME 8'h30
`define D_SUSPEND 8'hB0
`define D_RESET 8'hF0
`endif

// File: rtl/flash_host_pkg.sv
// Types shared by the flash host controller
package flash_host_pkg;
  // Operation codes written to the control register
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_RESET = 4'h1,
    OP_AUTOSEL = 4'h2,
    OP_PROGRAM = 4'h3,
    OP_CHIP_ERASE = 4'h4,
    OP_SECTOR_ERASE = 4'h5,
    OP_ADD_SECTOR = 4'h6,
    OP_SUSPEND = 4'h7,
    OP_RESUME = 4'h8
  } op_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SETUP = 5'b00010,
    S_STROBE = 5'b00100,
    S_HOLD = 5'b01000,
    S_NEXT = 5'b10000
  } state_t;
endpackage

// File: rtl/flash_host.sv
// Host controller driving a parallel flash by its command cycles
// Functional notes
// - Write only with select, strobe low, output-enable high
// - Host writes reset after timeout flag or autoselect
// - Two unlocks plus autoselect enter autoselect
// - Program is four write cycles
// - Chip erase is six write cycles
// - Extra sectors spaced under fifty microseconds; OP_ADD_SECTOR is sent when started, with no gap timed
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host
  import flash_host_pkg::*;
#(
  parameter int AW = 18,
  parameter int DW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [AW-1:0] fl_addr,
  output logic [DW-1:0] fl_dq_out,
  output logic fl_dq_oe,
  input wire logic [DW-1:0] fl_dq_in,
  output logic fl_cs_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_byte_n,
  input wire logic ready_busy_n
);
  // Unlock addresses need 12 bits; the data path is fixed at one word
  if (AW < 12 || AW > 32 || DW != 16) begin : g_bad_width
    $error("flash_host: unsupported widths");
  end

  logic [3:0] op_r;
  logic byte_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [DW-1:0] rdata_r;
  logic [3:0] tstrobe_r;
  logic busy_r;
  logic go_pulse;
  state_t state_r;
  logic [2:0] step_r;
  logic [3:0] cnt_r;
  logic is_write;
  logic [11:0] cyc_addr;
  logic [7:0] cyc_data;
  logic [2:0] last_step;
  logic last_is_read;
  logic use_full_addr;
  logic [AW-1:0] cyc_full_addr;

  // AHB-Lite slave: zero wait, address captured for the data phase
  logic wr_ph_r;
  logic [7:0] wa_r;
  logic ahb_go;
  assign ahb_go = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      wa_r <= 8'h00;
    end else if (hready) begin
      wr_ph_r <= ahb_go && hwrite;
      wa_r <= haddr[7:0];
    end
  end

  // Writes to ctrl while busy are dropped: one sequence at a time
  assign go_pulse = wr_ph_r && wa_r == `OFS_CTRL && hwdata[`CTRL_GO_BIT]
                    && !busy_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_r <= 4'h0;
      byte_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      tstrobe_r <= 4'(`TIMING_RESET);
    end else if (wr_ph_r) begin
      if (go_pulse) begin
        op_r <= hwdata[`CTRL_OP_LSB +: 4];
        byte_r <= hwdata[`CTRL_BYTE_BIT];
      end
      if (wa_r == `OFS_ADDR && !busy_r) addr_r <= hwdata[AW-1:0];
      if (wa_r == `OFS_WDATA && !busy_r) wdata_r <= hwdata[DW-1:0];
      if (wa_r == `OFS_TIMING) begin
        tstrobe_r <= (hwdata[3:0] < `STROBE_CYC_MIN) ? `STROBE_CYC_MIN
                     : hwdata[3:0];
      end
    end
  end

  // Read mux on the address captured in the address phase
  logic rd_ph_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_ph_r <= 1'b0;
    else if (hready) rd_ph_r <= ahb_go && !hwrite;
  end
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_ph_r) begin
      unique case (wa_r)
        `OFS_CTRL: hrdata = {23'h0, byte_r, op_r, 4'h0};
        `OFS_ADDR: hrdata = 32'(addr_r);
        `OFS_WDATA: hrdata = 32'(wdata_r);
        `OFS_STATUS: hrdata = {30'h0, ready_busy_n, busy_r};
        `OFS_RDATA: hrdata = 32'(rdata_r);
        `OFS_TIMING: hrdata = {28'h0, tstrobe_r};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Sequence tables; upper data and address bits left zero
  assign last_step = (op_r == OP_READ || op_r == OP_RESET ||
                      op_r == OP_SUSPEND || op_r == OP_RESUME ||
                      op_r == OP_ADD_SECTOR) ? 3'd0 :
                     (op_r == OP_CHIP_ERASE ||
                      op_r == OP_SECTOR_ERASE) ? 3'd5 : 3'd3;
  assign last_is_read = op_r == OP_READ || op_r == OP_AUTOSEL;
  assign is_write = !(last_is_read && step_r == last_step);
  assign use_full_addr = step_r == last_step &&
                         (op_r != OP_RESET && op_r != OP_SUSPEND &&
                          op_r != OP_RESUME && op_r != OP_CHIP_ERASE);
  always_comb begin
    cyc_addr = byte_r ? `UNLOCK1_B : `UNLOCK1_W;
    cyc_data = `D_UNLOCK1;
    unique case (step_r)
      3'd1, 3'd4: begin
        cyc_addr = byte_r ? `UNLOCK2_B : `UNLOCK2_W;
        cyc_data = `D_UNLOCK2;
      end
      3'd2: begin
        cyc_data = (op_r == OP_AUTOSEL) ? `D_AUTOSEL :
                   (op_r == OP_PROGRAM) ? `D_PROGRAM : `D_ERASE_SETUP;
      end
      3'd5: begin
        cyc_data = (op_r == OP_CHIP_ERASE) ? `D_CHIP_ERASE
                   : `D_SECTOR_ERASE;
      end
      default: begin
        cyc_data = `D_UNLOCK1;
      end
    endcase
    if (step_r == 3'd0 && last_step == 3'd0) begin
      cyc_data = (op_r == OP_RESET) ? `D_RESET :
                 (op_r == OP_SUSPEND) ? `D_SUSPEND :
                 (op_r == OP_RESUME) ? `D_RESUME : `D_SECTOR_ERASE;
    end
  end
  assign cyc_full_addr = use_full_addr ? addr_r : AW'(cyc_addr);

  // Cycle engine: address set, strobe low, strobe high with data held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
      step_r <= 3'd0;
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      rdata_r <= '0;
      fl_addr <= '0;
      fl_dq_out <= '0;
      fl_dq_oe <= 1'b0;
      fl_cs_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_byte_n <= 1'b1;
    end else begin
      unique case (state_r)
        S_IDLE: if (go_pulse) begin
          busy_r <= 1'b1;
          step_r <= 3'd0;
          state_r <= S_SETUP;
        end
        S_SETUP: begin
          fl_byte_n <= !byte_r;
          fl_addr <= cyc_full_addr;
          fl_dq_out <= DW'(cyc_data);
          if (use_full_addr && op_r == OP_PROGRAM) fl_dq_out <= wdata_r;
          fl_dq_oe <= is_write;
          fl_oe_n <= is_write;
          cnt_r <= tstrobe_r;
          state_r <= S_STROBE;
        end
        S_STROBE: begin
          fl_cs_n <= 1'b0;
          fl_we_n <= !is_write;
          if (cnt_r > 4'h1) cnt_r <= cnt_r - 4'h1;
          else state_r <= S_HOLD;
        end
        S_HOLD: begin
          fl_we_n <= 1'b1;
          if (!is_write) rdata_r <= fl_dq_in;
          state_r <= S_NEXT;
        end
        S_NEXT: begin
          fl_cs_n <= 1'b1;
          fl_oe_n <= 1'b1;
          fl_dq_oe <= 1'b0;
          if (step_r == last_step) begin
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end else begin
            step_r <= step_r + 3'd1;
            state_r <= S_SETUP;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Write strobe never low unless select low and output enable high
  a_write_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
    !fl_we_n |-> !fl_cs_n && fl_oe_n) else $error("bad write");
  a_reset_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> fl_we_n) else $error("we low at reset");
  sequence go_seq;
    state_r == S_IDLE && go_pulse;
  endsequence
  a_go_starts: assert property (@(posedge hclk) disable iff (!hresetn)
    go_seq |=> busy_r && state_r == S_SETUP)
    else $error("go not taken");
  a_data_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(fl_we_n) |-> fl_dq_oe && $stable(fl_dq_out))
    else $error("data moved at rise");
  a_addr_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    !fl_cs_n && !$rose(fl_cs_n) |-> $stable(fl_addr))
    else $error("addr moved in cycle");
  a_read_no_we: assert property (@(posedge hclk) disable iff (!hresetn)
    !fl_oe_n |-> fl_we_n && !fl_dq_oe) else $error("read drives");
  a_reset_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == S_STROBE && op_r == OP_RESET |-> fl_dq_out[7:0] == `D_RESET)
    else $error("bad reset data");
  a_chip_last: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == S_STROBE && op_r == OP_CHIP_ERASE && step_r == 3'd5
    |-> fl_dq_out[7:0] == `D_CHIP_ERASE) else $error("chip cmd");
  a_busy_ends: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == S_NEXT && step_r == last_step |=> !busy_r)
    else $error("busy stuck");
endmodule

// File: dv/flash_dev_model.sv
// Behavioural parallel flash answering the host controller's cycles
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int AW = 18,
  parameter int BUSY_NS = 2000,
  parameter logic [15:0] MFR_CODE = 16'h00C5, // Arbitrary identity value
  parameter logic [15:0] DEV_CODE = 16'h5A3C // Arbitrary identity value
) (
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] dq,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic byte_n,
  output logic [15:0] dq_out,
  output logic ready_busy_n
);
  logic [15:0] mem [16];
  logic [AW-1:0] a_lat;
  logic [15:0] rd;
  logic [2:0] step = 3'h0;
  logic autosel = 1'b0;
  logic busy = 1'b0;
  logic armed = 1'b0;
  wire [11:0] ul1 = byte_n ? 12'h0555 : 12'h0AAA;
  wire [11:0] ul2 = byte_n ? 12'h02AA : 12'h0555;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  assign ready_busy_n = !busy;
  // Identity codes in autoselect, array data otherwise
  always_comb begin
    if (autosel)
      rd = addr[7:0] == 8'h00 ? MFR_CODE :
           addr[7:0] == 8'h01 ? DEV_CODE : 16'h0000;
    else
      rd = mem[addr[3:0]];
  end
  // Undriven bus shows the inverse so a stale value never matches
  assign dq_out = (!cs_n && !oe_n) ? rd : ~rd;
  // Address taken as the later strobe falls; writes need output idle
  always @(negedge we_n or negedge cs_n) begin
    if (!we_n && !cs_n && oe_n) begin
      a_lat = addr;
      armed = 1'b1;
    end
  end
  // Data taken as the first strobe rises
  always @(posedge we_n or posedge cs_n) begin
    if (armed) begin
      armed = 1'b0;
      cmd(a_lat, dq);
    end
  end
  task automatic run;
    busy = 1'b1;
    busy <= #BUSY_NS 1'b0;
  endtask
  // Only the low data byte and low address bits decode commands
  task automatic cmd(input logic [AW-1:0] a, input logic [15:0] d);
    if (busy) return;
    if (d[7:0] == 8'hF0) begin
      step = 3'h0;
      autosel = 1'b0;
      return;
    end
    case (step)
      3'h0: step = (d[7:0] == 8'hAA && a[11:0] == ul1) ? 3'h1 : 3'h0;
      3'h1: step = (d[7:0] == 8'h55 && a[11:0] == ul2) ? 3'h2 : 3'h0;
      3'h2: begin
        if (a[11:0] == ul1 && d[7:0] == 8'h90) autosel = 1'b1;
        step = a[11:0] != ul1 ? 3'h0 : d[7:0] == 8'hA0 ? 3'h3 :
               d[7:0] == 8'h80 ? 3'h4 : 3'h0;
      end
      3'h3: begin
        mem[a[3:0]] &= byte_n ? d : {8'hFF, d[7:0]};
        run();
        step = 3'h0;
      end
      3'h4: step = (d[7:0] == 8'hAA && a[11:0] == ul1) ? 3'h5 : 3'h0;
      3'h5: step = (d[7:0] == 8'h55 && a[11:0] == ul2) ? 3'h6 : 3'h0;
      default: begin
        if (d[7:0] == 8'h10 || d[7:0] == 8'h30) begin
          foreach (mem[i]) mem[i] = 16'hFFFF;
          run();
        end
        step = 3'h0;
      end
    endcase
  endtask
endmodule

// File: dv/tb.sv
// Self-checking bench driving the flash host over AHB-Lite
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module tb;
  import flash_host_pkg::*;
  localparam logic [15:0] MFR = 16'h00C5; // Arbitrary identity value
  localparam logic [15:0] DEV = 16'h5A3C; // Arbitrary identity value
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, cs_n, we_n, oe_n, byte_n, dq_oe, rb_n;
  logic [17:0] fl_addr;
  logic [15:0] dq_o, dq_i;
  logic [31:0] wr_seen = 32'h0000_0000;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  always #4 hclk = ~hclk;
  flash_host uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .fl_addr,
    .fl_dq_out(dq_o), .fl_dq_oe(dq_oe), .fl_dq_in(dq_i), .fl_cs_n(cs_n),
    .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_byte_n(byte_n), .ready_busy_n(rb_n));
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev (.addr(fl_addr),
    .dq(dq_o), .cs_n, .we_n, .oe_n, .byte_n, .dq_out(dq_i),
    .ready_busy_n(rb_n));
  // Last write cycle on the flash pins: drive enable, low address, data
  always @(posedge we_n) wr_seen = {dq_oe, 3'h0, fl_addr[11:0], dq_o};
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One single transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    logic rdy;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'h2;
    hwrite <= w;
    // Look before each edge, so updates made at that edge cannot race
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      @(posedge hclk);
    end while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (rdy !== 1'b1);
  endtask
  task automatic op(input logic [3:0] c, input logic [31:0] a, d,
                    input logic bm = 1'b0);
    ahb(1'b1, `OFS_ADDR, a);
    ahb(1'b1, `OFS_WDATA, d);
    ahb(1'b1, `OFS_CTRL, {23'h0, bm, c, 4'h1});
    do ahb(1'b0, `OFS_STATUS, 0); while (rd[`ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic wait_rdy;
    do ahb(1'b0, `OFS_STATUS, 0); while (rd[`ST_RDY_BIT] !== 1'b1);
  endtask
  task automatic rd_flash(input logic [31:0] a, input logic [31:0] exp);
    op(OP_READ, a, 0);
    ahb(1'b0, `OFS_RDATA, 0);
    check(rd, exp);
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check({cs_n, we_n, oe_n}, 3'h7);
    ahb(1'b0, `OFS_TIMING, 0);
    check(rd, `TIMING_RESET);
    ahb(1'b0, 8'h18, 0);
    check(rd, 0);
    $display("test reset done");
    op(OP_PROGRAM, 3, 16'h1234);
    ahb(1'b0, `OFS_STATUS, 0);
    check(rd[`ST_RDY_BIT], 1'b0);
    op(OP_PROGRAM, 4, 0);
    wait_rdy();
    rd_flash(3, 16'h1234);
    rd_flash(4, 16'hFFFF);
    op(OP_PROGRAM, 3, 16'h00FF);
    wait_rdy();
    rd_flash(3, 16'h0034);
    op(OP_PROGRAM, 5, 16'h005A, 1'b1);
    wait_rdy();
    rd_flash(5, 16'hFF5A);
    $display("test program done");
    op(OP_AUTOSEL, 0, 0);
    ahb(1'b0, `OFS_RDATA, 0);
    check(rd, MFR);
    rd_flash(1, DEV);
    rd_flash(2, 0);
    op(OP_RESET, 0, 0);
    check(wr_seen, {1'b1, 3'h0, `UNLOCK1_W, 8'h00, `D_RESET});
    rd_flash(3, 16'h0034);
    $display("test autoselect done");
    op(OP_CHIP_ERASE, 0, 0);
    op(OP_PROGRAM, 3, 0);
    wait_rdy();
    rd_flash(3, 16'hFFFF);
    op(OP_PROGRAM, 6, 0);
    wait_rdy();
    op(OP_SECTOR_ERASE, 6, 0);
    wait_rdy();
    rd_flash(6, 16'hFFFF);
    op(OP_ADD_SECTOR, 6, 0);
    check(wr_seen, {1'b1, 3'h0, 12'h006, 8'h00, `D_SECTOR_ERASE});
    op(OP_SUSPEND, 0, 0);
    check(wr_seen, {1'b1, 3'h0, `UNLOCK1_W, 8'h00, `D_SUSPEND});
    op(OP_RESUME, 0, 0);
    check(wr_seen, {1'b1, 3'h0, `UNLOCK1_W, 8'h00, `D_RESUME});
    $display("test erase done");
    conclude();
  end
endmodule
